// ==== shared/sebtw_pkg.sv ====
// constants for the serial eeprom bus target write logic
package sebtw_pkg;

  // ****************************************************************
  // clock and write cycle timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  localparam int unsigned WRITE_CYCLE_MS  = 5;
  // longest time, rounded down to whole cycles
  localparam int unsigned WRITE_CYCLE_CYC = (SYS_CLK_HZ / 1000) * WRITE_CYCLE_MS;

  // ****************************************************************
  // word framing
  // ****************************************************************
  localparam logic [3:0] BITS_PER_WORD = 4'h8;  // count after the eighth data bit
  localparam logic [3:0] ACK_SLOT      = 4'h9;  // count after the ninth clock
  localparam int         PAGE_BYTES    = 8;
  localparam int         PAGE_OFS_W    = 3;

  // ****************************************************************
  // device address word layout
  // ****************************************************************
  localparam int TYPE_CODE_HI = 7;
  localparam int TYPE_CODE_LO = 4;
  localparam int SELECT_HI    = 3;
  localparam int SELECT_LO    = 1;
  localparam int DIR_BIT      = 0;
  localparam logic DIR_WRITE  = 1'b0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // ****************************************************************
  // states of the word sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    SEBTW_IDLE,
    SEBTW_DEVADDR,
    SEBTW_MEMADDR,
    SEBTW_WRDATA,
    SEBTW_RDDATA,
    SEBTW_RDHOLD,
    SEBTW_PROG
  } sebtw_state_t;

endpackage : sebtw_pkg

// ==== logic/sebtw_target.sv ====
// two-wire eeprom target: framing, address match, page write, write cycle
//
// Overview of operation
// - data sampled on clock rise; outgoing bits change after clock fall.
// - the data line is only pulled low or released.
// - data falling with clock high is a start; master starts every access.
// - data rising with clock high is a stop; after reads return to standby.
// - stop after write data launches the timed write cycle, then standby.
// - during the write cycle clock and data are ignored.
// - words are eight bits; receiver pulls low on ninth clock, sender releases.
// - in writes acknowledge device word, memory address and each data byte.
// - in reads acknowledge device word; on master ack send next address.
// - master nack then stop ends a read; device goes to standby.
// - without ack or stop after a sent byte, stay released, send nothing.
// - device word is type code, select bits two..zero, then direction.
// - respond only on type and select match, else back to standby.
// - direction zero starts a write, one starts a read.
// - unconnected select straps read as low.
// - byte write is device word, memory address, one data byte, stop.
// - further data bytes enter page mode, up to eight per write cycle.
// - page offset bits increment per byte and wrap, overwriting older bytes.
// - protect high: ack device word and address, nack data, no write.
// - protect low allows writes; reads ignore the protect input.
// - protected page write nacks the first data byte, array unchanged.
// - timed write cycle ends within five milliseconds of the stop.
// - during the write cycle device word gets no ack; ack once done.
`timescale 1ns/10ps
`default_nettype none

// ******************************************************************
// link side capture, clocked by the serial clock
// ******************************************************************
module sebtw_link_capture (
  input  wire  logic scl_in,
  input  wire  logic sda_in,
  output var   logic sampled_bit_out
);
  typedef struct packed {
    logic bit_q;
  } sebtw_link_t;

  sebtw_link_t r;
  sebtw_link_t n;

  // next value: data bit taken at each rising clock edge
  always_comb begin
    n       = r;
    n.bit_q = sda_in;
  end

  // register; no reset since the link clock may stand still
  always_ff @(posedge scl_in) begin
    r <= n;
  end

  assign sampled_bit_out = r.bit_q;
endmodule : sebtw_link_capture

// ******************************************************************
// target sequencer, clocked by the system clock
// ******************************************************************
module sebtw_target
  import sebtw_pkg::*;
#(
  parameter logic [3:0]  DEV_TYPE_CODE = 4'h6,           // arbitrary value
  parameter int unsigned WRITE_CYCLES  = WRITE_CYCLE_CYC
) (
  input  wire  logic        sys_clk_in,
  input  wire  logic        reset_in,
  input  wire  logic        scl_in,
  input  wire  logic        sda_in,
  output var   logic        sda_out,
  output var   logic        sda_oe_n_out,
  input  wire  logic [2:0]  select_strap_in,
  input  wire  logic        write_protect_in,
  input  wire  logic [7:0]  read_data_in,
  output var   logic [7:0]  read_addr_out,
  output var   logic [63:0] page_data_out,
  output var   logic [7:0]  page_mask_out,
  output var   logic [4:0]  page_base_out,
  output var   logic        prog_start_out,
  output var   logic        prog_busy_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic         scl_s1;
    logic         scl_s2;
    logic         scl_q;
    logic         sda_s1;
    logic         sda_s2;
    logic         sda_q;
    logic         wp_s1;
    logic         wp_s2;
    logic [2:0]   sel_s1;
    logic [2:0]   sel_s2;
    sebtw_state_t state;
    logic [3:0]   cnt;
    logic [7:0]   shift;
    logic         go_read;
    logic [7:0]   addr;
    logic [63:0]  page_buf;
    logic [7:0]   page_mask;
    logic [4:0]   page_base;
    logic         sda_oe_n;
    logic [16:0]  prog_cnt;
    logic         prog_start;
    logic         prog_busy;
  } sebtw_regs_t;

  sebtw_regs_t r;
  sebtw_regs_t n;
  logic        link_bit;

  // bit held by the link side since the last clock rise
  sebtw_link_capture u_link (
    .scl_in          (scl_in),
    .sda_in          (sda_in),
    .sampled_bit_out (link_bit)
  );

  // ****************************************************************
  // bus events from synchronised levels, device match, write cycle end
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic dev_match;
  logic ofs_last;

  always_comb begin
    scl_rise  = r.scl_s2 & ~r.scl_q;
    scl_fall  = ~r.scl_s2 & r.scl_q;
    start_ev  = r.scl_s2 & r.scl_q & ~r.sda_s2 & r.sda_q;
    stop_ev   = r.scl_s2 & r.scl_q & r.sda_s2 & ~r.sda_q;
    // field split; pulled-down straps arrive low
    dev_match = (r.shift[TYPE_CODE_HI:TYPE_CODE_LO] == DEV_TYPE_CODE) &&
                (r.shift[SELECT_HI:SELECT_LO] == r.sel_s2);
    ofs_last  = (r.prog_cnt == 17'(WRITE_CYCLES - 1));
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n            = r;
    n.scl_s1     = scl_in;
    n.scl_s2     = r.scl_s1;
    n.scl_q      = r.scl_s2;
    n.sda_s1     = sda_in;
    n.sda_s2     = r.sda_s1;
    n.sda_q      = r.sda_s2;
    n.wp_s1      = write_protect_in;
    n.wp_s2      = r.wp_s1;
    n.sel_s1     = select_strap_in;
    n.sel_s2     = r.sel_s1;
    n.prog_start = 1'b0;

    if (r.state == SEBTW_PROG) begin
      // bus ignored while programming; nothing acks
      n.sda_oe_n = 1'b1;
      n.prog_cnt = r.prog_cnt + 17'h00001;
      // cycle ends after the bounded count
      if (ofs_last) begin
        n.state     = SEBTW_IDLE;
        n.prog_cnt  = '0;
      end
    end else if (start_ev) begin
      // any start outside the write cycle restarts device word reception
      n.state    = SEBTW_DEVADDR;
      n.cnt      = '0;
      n.sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      n.sda_oe_n = 1'b1;
      n.cnt      = '0;
      // stop after write data launches programming
      if (r.state == SEBTW_WRDATA && r.page_mask != 8'h00) begin
        n.state      = SEBTW_PROG;
        n.prog_start = 1'b1;
        n.prog_cnt   = '0;
      end else begin
        // stop ends a read or any other sequence
        n.state = SEBTW_IDLE;
      end
    end else if (scl_rise) begin
      unique case (r.state)
        SEBTW_DEVADDR, SEBTW_MEMADDR, SEBTW_WRDATA: begin
          if (r.cnt < BITS_PER_WORD) begin
            // shift in the bit caught at the rise
            n.shift = {r.shift[6:0], link_bit};
          end
          n.cnt = r.cnt + 4'h1;
        end
        SEBTW_RDDATA: begin
          if (r.cnt == BITS_PER_WORD) begin
            // master ack low asks for the next byte
            if (!link_bit) begin
              n.addr          = r.addr + 8'h01;
              n.cnt           = ACK_SLOT;
            end else begin
              // no ack, stay released until start or stop
              n.state = SEBTW_RDHOLD;
            end
          end else begin
            n.cnt = r.cnt + 4'h1;
          end
        end
        SEBTW_IDLE, SEBTW_RDHOLD, SEBTW_PROG: begin
          n.cnt = r.cnt;
        end
      endcase
    end else if (scl_fall) begin
      unique case (r.state)
        SEBTW_DEVADDR, SEBTW_MEMADDR, SEBTW_WRDATA: begin
          if (r.cnt == BITS_PER_WORD) begin
            n.sda_oe_n = 1'b0;  // pull low for ack
            if (r.state == SEBTW_DEVADDR) begin
              // mismatch returns to standby with no ack
              if (!dev_match) begin
                n.state    = SEBTW_IDLE;
                n.sda_oe_n = 1'b1;
              end
              n.go_read = (r.shift[DIR_BIT] != DIR_WRITE);
            end else if (r.state == SEBTW_WRDATA) begin
              if (r.wp_s2) begin
                n.state    = SEBTW_IDLE;
                n.sda_oe_n = 1'b1;
              end else begin
                // store at page offset, offset wraps
                n.page_buf[r.addr[2:0]*8 +: 8] = r.shift;
                n.page_mask[r.addr[2:0]]       = 1'b1;
                n.addr[2:0]                    = r.addr[2:0] + 3'h1;
              end
            end else begin
              n.addr      = r.shift;
              n.page_base = r.shift[7:3];
              n.page_mask = 8'h00;
            end
          end else if (r.cnt == ACK_SLOT) begin
            n.sda_oe_n = 1'b1;
            n.cnt      = '0;
            if (r.state == SEBTW_DEVADDR) begin
              if (r.go_read) begin
                n.state    = SEBTW_RDDATA;
                n.shift    = read_data_in;
                n.sda_oe_n = read_data_in[7];
              end else begin
                n.state = SEBTW_MEMADDR;
              end
            end else if (r.state == SEBTW_MEMADDR) begin
              n.state = SEBTW_WRDATA;
            end
          end
        end
        SEBTW_RDDATA: begin
          if (r.cnt == ACK_SLOT) begin
            // next byte, first bit after the fall
            n.cnt      = '0;
            n.shift    = read_data_in;
            n.sda_oe_n = read_data_in[7];
          end else if (r.cnt == BITS_PER_WORD) begin
            // sender releases for the ninth clock
            n.sda_oe_n = 1'b1;
          end else begin
            // next bit after the fall, low or released
            n.shift    = {r.shift[6:0], 1'b0};
            n.sda_oe_n = r.shift[6];
          end
        end
        SEBTW_IDLE, SEBTW_RDHOLD, SEBTW_PROG: begin
          n.sda_oe_n = 1'b1;
        end
      endcase
    end
    // busy flag follows the next state so the output comes from a flop
    n.prog_busy = (n.state == SEBTW_PROG);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      r          <= '0;
      r.scl_s1   <= 1'b1;
      r.scl_s2   <= 1'b1;
      r.scl_q    <= 1'b1;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
      r.sda_q    <= 1'b1;
      r.state    <= SEBTW_IDLE;
      r.addr     <= ADDR_RESET;
      r.sda_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops, sda_out tied to a constant low; only a low level is ever driven
  assign sda_out        = 1'b0;
  assign sda_oe_n_out   = r.sda_oe_n;
  assign read_addr_out  = r.addr;
  assign page_data_out  = r.page_buf;
  assign page_mask_out  = r.page_mask;
  assign page_base_out  = r.page_base;
  assign prog_start_out = r.prog_start;
  assign prog_busy_out  = r.prog_busy;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  a_stop_programs: assert property (
    stop_ev && r.state == SEBTW_WRDATA && r.page_mask != 8'h00 |=> prog_busy_out && prog_start_out)
    else $error("stop after write data did not start programming");

  a_prog_quiet: assert property (
    r.state == SEBTW_PROG |-> ##1 sda_oe_n_out)
    else $error("data line driven during write cycle");

  a_prog_ends: assert property (
    r.state == SEBTW_PROG && ofs_last |=> r.state == SEBTW_IDLE && !prog_busy_out)
    else $error("write cycle did not end on its count");

  a_prog_bound: assert property (
    prog_busy_out |-> r.prog_cnt < 17'(WRITE_CYCLES))
    else $error("write cycle count overran");

  a_addr_mismatch: assert property (
    scl_fall && r.state == SEBTW_DEVADDR && r.cnt == BITS_PER_WORD && !dev_match
    |=> r.state == SEBTW_IDLE ##1 sda_oe_n_out)
    else $error("mismatched device word was acknowledged");

  a_memaddr_ack: assert property (
    scl_fall && r.state == SEBTW_MEMADDR && r.cnt == BITS_PER_WORD |=> !sda_oe_n_out && read_addr_out == $past(r.shift))
    else $error("memory address not acknowledged");

  a_protect_nack: assert property (
    scl_fall && r.state == SEBTW_WRDATA && r.cnt == BITS_PER_WORD && r.wp_s2
    |=> sda_oe_n_out && page_mask_out == $past(page_mask_out) && r.state == SEBTW_IDLE)
    else $error("protected data byte acknowledged or stored");

  a_page_wrap: assert property (
    scl_fall && r.state == SEBTW_WRDATA && r.cnt == BITS_PER_WORD && !r.wp_s2
    |=> read_addr_out[2:0] == $past(read_addr_out[2:0]) + 3'h1 && read_addr_out[7:3] == $past(read_addr_out[7:3]))
    else $error("page offset did not step within page");

  a_start_restart: assert property (
    start_ev && r.state != SEBTW_PROG |=> r.state == SEBTW_DEVADDR && r.cnt == 4'h0)
    else $error("start did not restart reception");

  a_read_hold: assert property (
    r.state == SEBTW_RDHOLD |-> ##1 sda_oe_n_out)
    else $error("data driven after read nack");

  c_prog_done: cover property (prog_busy_out ##1 !prog_busy_out);
  c_read_next: cover property (r.state == SEBTW_RDDATA && r.cnt == ACK_SLOT);
  c_protected: cover property (scl_fall && r.state == SEBTW_WRDATA && r.wp_s2 && r.cnt == BITS_PER_WORD);

endmodule : sebtw_target

`default_nettype wire

// ==== verification/sebtw_bus_master.sv ====
// bus master model for the two-wire eeprom target
`timescale 1ns/10ps
`default_nettype none

module sebtw_bus_master (
  input  wire logic sys_clk_in,
  input  wire logic sda_line_in,
  output var  logic scl_out,
  output var  logic sda_pull_out
);
  // ****************************************
  // idle bus: clock stands high, data free
  // ****************************************
  initial begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end

  // wait whole system clock cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc

  // one bit: data set in low phase, line sampled in high phase
  task automatic clk_bit(input logic drv, output logic smp);
    cyc(10);
    sda_pull_out <= ~drv;
    cyc(20);
    scl_out <= 1'b1;
    cyc(10);
    smp = sda_line_in;
    cyc(10);
    scl_out <= 1'b0;
  endtask : clk_bit

  // start, also usable as repeated start
  task automatic start_cond;
    cyc(10);
    sda_pull_out <= 1'b0;
    cyc(20);
    scl_out <= 1'b1;
    cyc(20);
    sda_pull_out <= 1'b1;
    cyc(20);
    scl_out <= 1'b0;
  endtask : start_cond

  // stop, bus left idle
  task automatic stop_cond;
    cyc(10);
    sda_pull_out <= 1'b1;
    cyc(20);
    scl_out <= 1'b1;
    cyc(20);
    sda_pull_out <= 1'b0;
    cyc(30);
  endtask : stop_cond

  // byte out msb first, ninth bit read back
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack_n);
  endtask : send_byte

  // byte in msb first, then master acknowledge
  task automatic recv_byte(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(ack_n, s);
  endtask : recv_byte
endmodule : sebtw_bus_master

`default_nettype wire

// ==== verification/serial_eeprom_bus_target_write_tb_top.sv ====
// self-checking bench for the two-wire eeprom target
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_bus_target_write_tb_top;
  import sebtw_pkg::*;

  localparam logic [3:0]  TYPE_CODE = 4'h5;  // arbitrary value
  localparam int unsigned WR_CYC    = 1000;

  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic [2:0]  strap    = 3'h3;
  logic        wp       = 1'b0;
  logic [7:0]  rd_data  = 8'h00;
  logic        scl, sda_pull, sda_line, sda_out, sda_oe_n, prev_oe_n, prog_start, prog_busy;
  logic [7:0]  rd_addr, page_mask;
  logic [63:0] page_data;
  logic [4:0]  page_base;
  int          fails, num_checks, start_cnt, busy_run, last_run;

  // ****************************************
  // clock, wire and instances
  // ****************************************
  always #25 sys_clk = ~sys_clk;
  // pulled-up data wire
  assign sda_line = (sda_pull || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
  // array model, one cycle latency
  always @(posedge sys_clk) rd_data <= rd_addr ^ 8'h5a;

  sebtw_target #(.DEV_TYPE_CODE(TYPE_CODE), .WRITE_CYCLES(WR_CYC)) u_sebtw_target (
    .sys_clk_in       (sys_clk),
    .reset_in         (reset),
    .scl_in           (scl),
    .sda_in           (sda_line),
    .sda_out          (sda_out),
    .sda_oe_n_out     (sda_oe_n),
    .select_strap_in  (strap),
    .write_protect_in (wp),
    .read_data_in     (rd_data),
    .read_addr_out    (rd_addr),
    .page_data_out    (page_data),
    .page_mask_out    (page_mask),
    .page_base_out    (page_base),
    .prog_start_out   (prog_start),
    .prog_busy_out    (prog_busy)
  );

  sebtw_bus_master u_sebtw_bus_master (
    .sys_clk_in   (sys_clk),
    .sda_line_in  (sda_line),
    .scl_out      (scl),
    .sda_pull_out (sda_pull)
  );

  // pin monitor and write cycle bookkeeping
  always @(posedge sys_clk) begin
    prev_oe_n <= sda_oe_n;
    if (prog_start === 1'b1) start_cnt <= start_cnt + 1;
    if (prog_busy === 1'b1) busy_run <= busy_run + 1;
    else if (busy_run != 0) begin
      last_run <= busy_run;
      busy_run <= 0;
    end
    if (!reset && sda_out !== 1'b0) begin
      fails++;
      $display("ERROR %0t data line driven high", $time);
    end
    if (!reset && sda_oe_n !== prev_oe_n && scl === 1'b1) begin
      fails++;
      $display("ERROR %0t data output changed with clock high", $time);
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [79:0] got, input logic [79:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  function automatic logic [7:0] dw(input logic [2:0] sel, input logic dir);
    return {TYPE_CODE, sel, dir};
  endfunction : dw

  task automatic sta;
    u_sebtw_bus_master.start_cond();
  endtask : sta

  task automatic sto;
    u_sebtw_bus_master.stop_cond();
  endtask : sto

  task automatic tx(input logic [7:0] d, output logic a);
    u_sebtw_bus_master.send_byte(d, a);
  endtask : tx

  task automatic rx(input logic a, output logic [7:0] d);
    u_sebtw_bus_master.recv_byte(a, d);
  endtask : rx

  // address word alone, then stop
  task automatic poll(input logic [7:0] w, output logic a);
    sta();
    tx(w, a);
    sto();
  endtask : poll

  task automatic wait_idle;
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    check(n < 4000, 1'b1, "cycle ends");
  endtask : wait_idle

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_byte_write;
    logic a0, a1, a2;
    int   s0;
    s0 = start_cnt;
    sta();
    tx(dw(3'h3, DIR_WRITE), a0);
    tx(8'h2d, a1);
    tx(8'ha5, a2);
    sto();
    check({a0, a1, a2}, 3'h0, "write acks");
    check(start_cnt - s0, 8'h1, "cycle launch");
    check({page_base, page_mask, page_data[47:40]}, {5'h05, 8'h20, 8'ha5}, "stored byte");
    poll(dw(3'h3, DIR_WRITE), a0);
    check({a0, prog_busy}, 2'h3, "busy poll");
    wait_idle();
    check(last_run, WR_CYC, "cycle length");
    poll(dw(3'h3, DIR_WRITE), a0);
    check({a0, start_cnt - s0}, {1'b0, 32'h1}, "ready poll");
  endtask : t_byte_write

  task automatic t_page_wrap;
    logic        a, any;
    logic [63:0] exp;
    any = 1'b0;
    exp = 64'h0;
    sta();
    tx(dw(3'h3, DIR_WRITE), a);
    tx(8'h16, a);
    for (int i = 0; i < 9; i++) begin
      tx(8'h10 + i[7:0], a);
      any = any | a;
      exp[((6 + i) % 8) * 8 +: 8] = 8'h10 + i[7:0];
    end
    sto();
    check(any, 1'b0, "page acks");
    check({page_base, page_mask, page_data}, {5'h02, 8'hff, exp}, "page wrap");
    wait_idle();
  endtask : t_page_wrap

  task automatic t_protect_read;
    logic       a0, a1, a2;
    logic [7:0] d0, d1, d2;
    int         s0;
    s0 = start_cnt;
    wp <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sta();
    tx(dw(3'h3, DIR_WRITE), a0);
    tx(8'h40, a1);
    tx(8'h77, a2);
    sto();
    check({a0, a1, a2}, 3'h1, "protect acks");
    check(start_cnt - s0, 8'h0, "no protected write");
    sta();
    tx(dw(3'h3, DIR_WRITE), a0);
    tx(8'h40, a1);
    sta();
    tx(dw(3'h3, 1'b1), a2);
    rx(1'b0, d0);
    rx(1'b1, d1);
    rx(1'b1, d2);
    sto();
    wp <= 1'b0;
    check({a0, a1, a2}, 3'h0, "read acks");
    check({d0, d1, d2, rd_addr}, {8'h1a, 8'h1b, 8'hff, 8'h41}, "read data");
  endtask : t_protect_read

  task automatic t_restart;
    logic a0, s;
    sta();
    for (int i = 0; i < 4; i++) begin
      u_sebtw_bus_master.clk_bit(i[0], s);
    end
    poll(dw(3'h3, DIR_WRITE), a0);
    check(a0, 1'b0, "restart ack");
  endtask : t_restart

  task automatic t_select;
    logic a0, a1;
    for (int s = 0; s < 8; s++) begin
      strap <= s[2:0];
      repeat (4) @(posedge sys_clk);
      poll(dw(s[2:0], DIR_WRITE), a0);
      poll(dw(~s[2:0], DIR_WRITE), a1);
      check({a0, a1}, 2'h1, "select match");
    end
    poll({~TYPE_CODE, strap, DIR_WRITE}, a0);
    check(a0, 1'b1, "type mismatch");
  endtask : t_select

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({sda_oe_n, prog_busy, prog_start, rd_addr, page_mask, page_base, page_data},
          {3'h4, ADDR_RESET, 8'h00, 5'h00, 64'h0}, "reset values");
    t_byte_write();
    t_page_wrap();
    t_protect_read();
    t_restart();
    t_select();
    close_out();
  end

  // watchdog
  initial begin
    // scenarios need about 25k cycles; allow a bit over twice that
    repeat (60000) @(posedge sys_clk);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule : serial_eeprom_bus_target_write_tb_top

`default_nettype wire
